// *** src/sdamd_decoder.sv ***
// Address, bank-select and data-mask decoder of a four-bank SDRAM.
`timescale 1ns/1ps

// What this block does
// R1 - A write beat with its lane mask sampled high is dropped and the array lane is not written.
// R2 - A read lane whose mask is sampled high has its output driver off two clocks later.
// R3 - In the x16 setup the low mask governs data lines 0-7 and the high mask lines 8-15.
// R4 - In the x4 and x8 setups the low mask is ignored and the high mask covers the whole bus.
// R5 - The two bank-select bits taken with activate, read, write or precharge choose the bank.
// R6 - An activate captures all thirteen address lines as the row of the selected bank.
// R7 - Read and write take column lines 0-9 plus 11 in x4, 0-9 in x8 and 0-8 in x16.
// R8 - Line 10 with a read or write selects auto precharge at the end of the burst.
// R9 - Line 10 with a precharge selects all banks when high and one bank when low.
// R10 - A mode set command loads the address lines into the mode register.
// R11 - The data bus is sixteen, eight or four lines wide by setup, the rest unused.
// R12 - A single-bank precharge acts on the bank given by the bank-select bits.
// R13 - Every input is registered on the rising clock edge.
// R14 - With chip select high commands are ignored but the masks keep acting.
// R15 - The controller raises the read mask one clock ahead of the beat to suppress.
module sdamd_decoder
  import sdamd_pkg::*;
#(
  parameter sdamd_cfg_type CONFIG = SDAMD_CFG_X16
) (
  // Clock and reset.
  input  wire logic                                   clk_i,
  input  wire logic                                   reset_i,
  // Controller request pins.
  input  wire sdamd_pkg::sdamd_req_type               req_i,
  // Data lines from the pins, with beat qualifiers from the burst engine.
  input  wire logic [sdamd_pkg::DATA_WIDTH_MAX-1:0]   data_lines_i,
  input  wire logic                                   write_beat_i,
  input  wire logic                                   read_beat_i,
  input  wire logic [sdamd_pkg::DATA_WIDTH_MAX-1:0]   read_data_i,
  // Data lines toward the pins.
  output logic      [sdamd_pkg::DATA_WIDTH_MAX-1:0]   data_lines_o,
  output logic      [sdamd_pkg::DATA_WIDTH_MAX-1:0]   data_lines_oe_o,
  // Array write port.
  output logic      [sdamd_pkg::DATA_WIDTH_MAX-1:0]   array_wdata_o,
  output logic      [sdamd_pkg::DATA_WIDTH_MAX-1:0]   array_wbit_en_o,
  output logic                                        array_write_o,
  // Decoded commands.
  output sdamd_pkg::sdamd_row_type                    row_o,
  output sdamd_pkg::sdamd_col_type                    col_o,
  output sdamd_pkg::sdamd_pre_type                    pre_o,
  output logic      [sdamd_pkg::ADDR_WIDTH-1:0]       mode_reg_o,
  output logic                                        mode_load_o
);

  import sdamd_pkg::*;

  localparam int DW = (CONFIG == SDAMD_CFG_X16) ? 16 : (CONFIG == SDAMD_CFG_X8) ? 8 : 4;

  ////////////////////////////////////////////////////////////////////////////////
  // Elaboration checks.

  if (CONFIG != SDAMD_CFG_X4 && CONFIG != SDAMD_CFG_X8 &&
      CONFIG != SDAMD_CFG_X16) begin : g_bad_config
    $error("sdamd_decoder supports only the x4, x8 and x16 setups.");
  end

  // The read mask line needs one stage of its own ahead of the output register.
  if (READ_MASK_LAT < 2) begin : g_bad_latency
    $error("sdamd_decoder needs a read mask latency of at least two clocks.");
  end

  // The column field must hold lines 0-9 and the extra x4 line, which must exist.
  if (COL_WIDTH_MAX < COL_X8_TOP + 2 || COL_X4_HIGH >= ADDR_WIDTH) begin : g_bad_column
    $error("sdamd_decoder column field cannot hold the x4 column.");
  end

  // The precharge select line sits above every column bit of the x8 and x16 setups.
  if (PRE_SEL_BIT >= ADDR_WIDTH || PRE_SEL_BIT <= COL_X8_TOP) begin : g_bad_pre_line
    $error("sdamd_decoder precharge select line is out of place.");
  end

  // Every code of the bank-select bits must name a bank.
  if (NUM_BANKS != (1 << BANK_WIDTH)) begin : g_bad_banks
    $error("sdamd_decoder bank count does not match the bank-select width.");
  end

  // Two byte lanes must cover the widest data bus.
  if (DATA_WIDTH_MAX != 2 * LANE_WIDTH) begin : g_bad_lanes
    $error("sdamd_decoder needs exactly two byte lanes on the widest bus.");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Expands the two lane masks to one mask bit per data line.
  function automatic logic [DATA_WIDTH_MAX-1:0] lane_bits(input logic [1:0] m);
    logic [DATA_WIDTH_MAX-1:0] bits;
    bits = '0;
    if (CONFIG == SDAMD_CFG_X16) begin
      bits = {{LANE_WIDTH{m[1]}}, {LANE_WIDTH{m[0]}}}; // R3
    end else begin
      bits = {DATA_WIDTH_MAX{m[1]}}; // R4
    end
    return bits;
  endfunction

  // Lines that exist in this setup; the others are left unconnected.
  function automatic logic [DATA_WIDTH_MAX-1:0] used_bits();
    logic [DATA_WIDTH_MAX-1:0] bits;
    bits = '0;
    for (int i = 0; i < DW; i++) begin
      bits[i] = 1'b1; // R11
    end
    return bits;
  endfunction

  // Gathers the column bits that this setup reads from the address lines.
  function automatic logic [COL_WIDTH_MAX-1:0] column_of(input logic [ADDR_WIDTH-1:0] a);
    logic [COL_WIDTH_MAX-1:0] c;
    c = '0;
    case (CONFIG)
      SDAMD_CFG_X4: begin
        c = {a[COL_X4_HIGH], a[COL_X8_TOP:0]}; // R7
      end
      SDAMD_CFG_X8: begin
        c[COL_X8_TOP:0] = a[COL_X8_TOP:0]; // R7
      end
      default: begin
        c[COL_X16_TOP:0] = a[COL_X16_TOP:0]; // R7
      end
    endcase
    return c;
  endfunction

  // A command counts only when chip select was sampled low with it.
  function automatic logic takes(input sdamd_req_type r, input sdamd_cmd_type c);
    return !r.chip_select_n && r.command == c; // R14
  endfunction

  // Turns the two bank-select bits into one enable per bank.
  function automatic logic [NUM_BANKS-1:0] bank_onehot_of(input logic [BANK_WIDTH-1:0] b);
    logic [NUM_BANKS-1:0] hot;
    hot    = '0;
    hot[b] = 1'b1; // R5 R12
    return hot;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Input registers.

  sdamd_req_type             req_reg;
  logic [DATA_WIDTH_MAX-1:0] wdata_reg;
  logic                      wbeat_reg;
  logic                      rbeat_reg;
  logic [DATA_WIDTH_MAX-1:0] rdata_reg;

  // Command, address, bank-select and mask pins.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      req_reg               <= '0;
      req_reg.chip_select_n <= 1'b1;
      req_reg.command       <= SDAMD_CMD_NONE;
    end else begin
      req_reg <= req_i; // R13
    end
  end

  // Write data with its beat qualifier; lines that do not exist read as zero.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wdata_reg <= '0;
      wbeat_reg <= 1'b0;
    end else begin
      wdata_reg <= data_lines_i & used_bits(); // R13 R11
      wbeat_reg <= write_beat_i;
    end
  end

  // Array read data with its beat qualifier.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_reg <= '0;
      rbeat_reg <= 1'b0;
    end else begin
      rdata_reg <= read_data_i & used_bits(); // R11
      rbeat_reg <= read_beat_i;
    end
  end

  logic [DATA_WIDTH_MAX-1:0] mask_bits;
  logic [DATA_WIDTH_MAX-1:0] keep_bits;
  logic [NUM_BANKS-1:0]      bank_dec;
  logic                      act_hit;
  logic                      rd_hit;
  logic                      wr_hit;
  logic                      pre_hit;
  logic                      mset_hit;

  assign mask_bits = lane_bits({req_reg.high_byte_mask, req_reg.low_byte_mask}); // R3 R4
  assign keep_bits = ~mask_bits & used_bits(); // R1 R11
  assign bank_dec  = bank_onehot_of(req_reg.bank_select); // R5
  assign act_hit   = takes(req_reg, SDAMD_CMD_ACTIVATE); // R14
  assign rd_hit    = takes(req_reg, SDAMD_CMD_READ);
  assign wr_hit    = takes(req_reg, SDAMD_CMD_WRITE);
  assign pre_hit   = takes(req_reg, SDAMD_CMD_PRECHARGE);
  assign mset_hit  = takes(req_reg, SDAMD_CMD_MODE_SET);

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode.

  // Row capture on an activate.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      row_o <= '0;
    end else begin
      row_o.valid <= act_hit;
      row_o.bank  <= req_reg.bank_select; // R5
      row_o.row   <= req_reg.muxed_address_lines; // R6
    end
  end

  // Column capture on a read or a write; the fields mean something only with valid.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      col_o <= '0;
    end else begin
      col_o.valid          <= rd_hit || wr_hit;
      col_o.is_write       <= wr_hit;
      col_o.bank           <= req_reg.bank_select; // R5
      col_o.column         <= column_of(req_reg.muxed_address_lines); // R7
      col_o.auto_precharge <= req_reg.muxed_address_lines[PRE_SEL_BIT]; // R8
    end
  end

  // Precharge target: every bank, or the one that the bank-select bits name.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pre_o <= '0;
    end else begin
      pre_o.valid       <= pre_hit;
      pre_o.all_banks   <= req_reg.muxed_address_lines[PRE_SEL_BIT]; // R9
      pre_o.bank_onehot <= req_reg.muxed_address_lines[PRE_SEL_BIT] ?
                           {NUM_BANKS{1'b1}} : bank_dec; // R9 R12
    end
  end

  // Mode register; it keeps its op-code until the next mode set.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mode_load_o <= 1'b0;
      mode_reg_o  <= '0;
    end else begin
      mode_load_o <= mset_hit;
      if (mset_hit) begin
        mode_reg_o <= req_reg.muxed_address_lines; // R10
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Write masking.

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      array_write_o   <= 1'b0;
      array_wdata_o   <= '0;
      array_wbit_en_o <= '0;
    end else begin
      // A beat with every lane masked leaves the array untouched.
      array_write_o   <= wbeat_reg && (keep_bits != '0); // R1 R14
      array_wdata_o   <= wdata_reg;
      array_wbit_en_o <= wbeat_reg ? keep_bits : '0; // R1
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read output disable with two-clock latency.

  // One stage here and the output register below make up the two-clock latency.
  logic [1:0] rmask_late;

  sdamd_lane_delay #(
    .WIDTH (2),
    .DEPTH (READ_MASK_LAT - 1)
  ) u_rmask_delay (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .data_i  ({req_reg.high_byte_mask, req_reg.low_byte_mask}),
    .data_o  (rmask_late)
  );

  // Read data toward the pins, one beat a cycle.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      data_lines_o <= '0;
    end else begin
      data_lines_o <= rdata_reg;
    end
  end

  // Drivers of masked lanes stay off; unconnected lines are never driven.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      data_lines_oe_o <= '0;
    end else begin
      data_lines_oe_o <= rbeat_reg ? (~lane_bits(rmask_late) & used_bits()) : '0; // R2 R11 R15
    end
  end

endmodule

// *** shared/sdamd_pkg.sv ***
// Package of constants and carrier types for the SDRAM address and mask decoder.
package sdamd_pkg;

  localparam int ADDR_WIDTH     = 13;
  localparam int BANK_WIDTH     = 2;
  localparam int NUM_BANKS      = 4;
  localparam int DATA_WIDTH_MAX = 16;
  localparam int LANE_WIDTH     = 8;
  localparam int COL_WIDTH_MAX  = 11;
  localparam int READ_MASK_LAT  = 2;
  localparam int PRE_SEL_BIT    = 10;
  localparam int COL_X4_HIGH    = 11;
  localparam int COL_X8_TOP     = 9;
  localparam int COL_X16_TOP    = 8;

  typedef enum logic [1:0] {
    SDAMD_CFG_X4  = 2'h0,
    SDAMD_CFG_X8  = 2'h1,
    SDAMD_CFG_X16 = 2'h2
  } sdamd_cfg_type;

  typedef enum logic [5:0] {
    SDAMD_CMD_NONE      = 6'h01,
    SDAMD_CMD_ACTIVATE  = 6'h02,
    SDAMD_CMD_READ      = 6'h04,
    SDAMD_CMD_WRITE     = 6'h08,
    SDAMD_CMD_PRECHARGE = 6'h10,
    SDAMD_CMD_MODE_SET  = 6'h20
  } sdamd_cmd_type;

  typedef struct packed {
    logic                  chip_select_n;
    sdamd_cmd_type         command;
    logic [BANK_WIDTH-1:0] bank_select;
    logic [ADDR_WIDTH-1:0] muxed_address_lines;
    logic                  low_byte_mask;
    logic                  high_byte_mask;
  } sdamd_req_type;

  typedef struct packed {
    logic                     valid;
    logic [BANK_WIDTH-1:0]    bank;
    logic [ADDR_WIDTH-1:0]    row;
  } sdamd_row_type;

  typedef struct packed {
    logic                     valid;
    logic                     is_write;
    logic [BANK_WIDTH-1:0]    bank;
    logic [COL_WIDTH_MAX-1:0] column;
    logic                     auto_precharge;
  } sdamd_col_type;

  typedef struct packed {
    logic                  valid;
    logic                  all_banks;
    logic [NUM_BANKS-1:0]  bank_onehot;
  } sdamd_pre_type;

endpackage

// *** src/sdamd_lane_delay.sv ***
// Fixed-latency shift line that delays the per-lane read mask.
`timescale 1ns/1ps

module sdamd_lane_delay #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 2
) (
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  // Data in and delayed data out.
  input  wire logic [WIDTH-1:0] data_i,
  output logic      [WIDTH-1:0] data_o
);

  logic [WIDTH-1:0] stage_reg [DEPTH];

  if (DEPTH < 1 || WIDTH < 1) begin : g_bad_size
    $error("sdamd_lane_delay needs positive width and depth.");
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        stage_reg[i] <= '0;
      end
    end else begin
      stage_reg[0] <= data_i;
      for (int i = 1; i < DEPTH; i++) begin
        stage_reg[i] <= stage_reg[i-1];
      end
    end
  end

  assign data_o = stage_reg[DEPTH-1];

endmodule

// *** sim/sdamd_props.sv ***
// Concurrent checks of the decoder pin behaviour.
`timescale 1ns/1ps
module sdamd_props
  import sdamd_pkg::*;
#(
  parameter sdamd_cfg_type CONFIG = SDAMD_CFG_X16
) (
  // Clock and reset.
  input wire logic                     clk_i,
  input wire logic                     reset_i,
  // Watched inputs.
  input wire sdamd_pkg::sdamd_req_type req_i,
  input wire logic                     write_beat_i,
  input wire logic                     read_beat_i,
  // Watched outputs.
  input wire logic [15:0]              data_lines_oe_o,
  input wire logic [15:0]              array_wbit_en_o,
  input wire sdamd_pkg::sdamd_row_type row_o,
  input wire sdamd_pkg::sdamd_col_type col_o,
  input wire sdamd_pkg::sdamd_pre_type pre_o,
  input wire logic [12:0]              mode_reg_o,
  input wire logic                     mode_load_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  localparam logic X16 = (CONFIG == SDAMD_CFG_X16);
  localparam logic [15:0] USED = X16 ? 16'hffff : (CONFIG == SDAMD_CFG_X8 ? 16'h00ff : 16'h000f);
  wire       cs = !req_i.chip_select_n;
  wire [12:0] a = req_i.muxed_address_lines;
  wire        h = req_i.high_byte_mask;
  // Lanes that a beat may use, after the masks in force for this setup.
  wire [15:0] keep = X16 ? {{8{!h}}, {8{!req_i.low_byte_mask}}} : (h ? 16'h0000 : USED);
  wire [10:0] cexp = X16 ? {2'b00, a[8:0]} : (USED[7] ? {1'b0, a[9:0]} : {a[11], a[9:0]});
  a_row_capture: assert property (cs && req_i.command == SDAMD_CMD_ACTIVATE |-> ##2
    row_o == {1'b1, $past(req_i.bank_select, 2), $past(a, 2)}) else $error("bad row");
  a_cs_ignores: assert property (req_i.chip_select_n |-> ##2
    !(row_o.valid || col_o.valid || pre_o.valid || mode_load_o)) else $error("bad cs");
  a_col_fields: assert property (cs && (req_i.command == SDAMD_CMD_READ ||
    req_i.command == SDAMD_CMD_WRITE) |-> ##2 col_o.valid && col_o.bank ==
    $past(req_i.bank_select, 2) && col_o.auto_precharge == $past(a[10], 2))
    else $error("bad column fields");
  a_col_width: assert property (cs && req_i.command == SDAMD_CMD_READ |-> ##2
    col_o.column == $past(cexp, 2)) else $error("bad column");
  a_pre_decode: assert property (cs && req_i.command == SDAMD_CMD_PRECHARGE |-> ##2
    pre_o == ($past(a[10], 2) ? 6'h3f : {2'b10, 4'h1 << $past(req_i.bank_select, 2)}))
    else $error("bad precharge");
  a_mode_load: assert property (cs && req_i.command == SDAMD_CMD_MODE_SET |-> ##2
    mode_load_o && mode_reg_o == $past(a, 2)) else $error("bad mode load");
  a_write_mask: assert property (write_beat_i |-> ##2 array_wbit_en_o == $past(keep, 2))
    else $error("bad write mask");
  a_read_hiz: assert property (read_beat_i |-> ##2 data_lines_oe_o == $past(keep, 3))
    else $error("bad read mask");
  a_unused_lines: assert property (((data_lines_oe_o | array_wbit_en_o) & ~USED) == 16'h0000)
    else $error("unused line active");
endmodule

bind sdamd_decoder sdamd_props #(.CONFIG(CONFIG)) u_props (.clk_i, .reset_i, .req_i,
  .write_beat_i, .read_beat_i, .data_lines_oe_o, .array_wbit_en_o, .row_o, .col_o, .pre_o,
  .mode_reg_o, .mode_load_o);

// *** sim/sdamd_ctrl.sv ***
// Behavioural memory controller that drives the decoder pins.
`timescale 1ns/1ps
module sdamd_ctrl
  import sdamd_pkg::*;
(
  // Clock.
  input  wire logic                clk_i,
  // Pins toward the decoder.
  output sdamd_pkg::sdamd_req_type req_o,
  output logic [15:0]              data_o,
  output logic                     wbeat_o,
  output logic                     rbeat_o
);
  localparam sdamd_req_type IDLE = '{1'b0, SDAMD_CMD_NONE, 2'h0, 13'h0000, 1'b0, 1'b0};
  initial begin
    req_o = IDLE;
    {wbeat_o, rbeat_o, data_o} = 18'h0_0000;
  end
  // Released address pins show the inverse, so stale values cannot pass.
  task automatic cmd(input sdamd_cmd_type c, input logic n, input logic [1:0] b,
                     input logic [12:0] a);
    @(posedge clk_i);
    req_o <= '{n, c, b, a, 1'b0, 1'b0};
    @(posedge clk_i);
    req_o <= '{1'b0, SDAMD_CMD_NONE, ~b, ~a, 1'b0, 1'b0};
  endtask
  // A read mask leads its beat, a write mask goes with its beat.
  task automatic beat(input logic rd, input logic n, input logic [1:0] m, input logic [15:0] d);
    @(posedge clk_i);
    req_o.chip_select_n <= n;
    {req_o.high_byte_mask, req_o.low_byte_mask} <= m;
    {wbeat_o, data_o} <= {!rd, d};
    if (rd) begin
      @(posedge clk_i);
      {req_o.high_byte_mask, req_o.low_byte_mask} <= 2'b00;
      rbeat_o <= 1'b1;
    end
    @(posedge clk_i);
    req_o <= IDLE;
    {wbeat_o, rbeat_o, data_o} <= {2'b00, ~d};
  endtask
endmodule

// *** sim/sdamd_decoder_tb_top.sv ***
// Self-checking testbench of the SDRAM address and mask decoder.
`timescale 1ns/1ps
module sdamd_decoder_tb_top;
  import sdamd_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  sdamd_req_type req;
  logic [15:0]   din, dq, oe, wd, en, oen [2], enn [2];
  logic          wb, rb, wr, ml;
  logic [12:0]   mr;
  sdamd_row_type row;
  sdamd_col_type col, coln [2];
  sdamd_pre_type pre;
  int fails = 0;
  int checks = 0;
  always #10 clk_i = ~clk_i;
  sdamd_ctrl u_ctrl (.clk_i, .req_o(req), .data_o(din), .wbeat_o(wb), .rbeat_o(rb));
  sdamd_decoder #(.CONFIG(SDAMD_CFG_X16)) dut (.clk_i, .reset_i, .req_i(req), .data_lines_i(din),
    .write_beat_i(wb), .read_beat_i(rb), .read_data_i(din), .data_lines_o(dq),
    .data_lines_oe_o(oe), .array_wdata_o(wd), .array_wbit_en_o(en), .array_write_o(wr),
    .row_o(row), .col_o(col), .pre_o(pre), .mode_reg_o(mr), .mode_load_o(ml));
  for (genvar g = 0; g < 2; g++) begin : narrow
    sdamd_decoder #(.CONFIG(g ? SDAMD_CFG_X4 : SDAMD_CFG_X8)) dut (.clk_i, .reset_i,
      .req_i(req), .data_lines_i(din), .write_beat_i(wb), .read_beat_i(rb), .read_data_i(din),
      .data_lines_o(), .data_lines_oe_o(oen[g]), .array_wdata_o(), .array_wbit_en_o(enn[g]),
      .array_write_o(), .row_o(), .col_o(coln[g]), .pre_o(), .mode_reg_o(), .mode_load_o());
  end
  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic land;
    @(posedge clk_i);
    #1;
  endtask
  task automatic t_cmds;
    for (int i = 0; i < 4; i++) begin
      u_ctrl.cmd(SDAMD_CMD_ACTIVATE, 1'b0, i[1:0], 13'h1a5c ^ 13'(i));
      land();
      cmp(row, {1'b1, i[1:0], 13'h1a5c ^ 13'(i)});
      u_ctrl.cmd(i[1] ? SDAMD_CMD_WRITE : SDAMD_CMD_READ, 1'b0, i[1:0], 13'h0b5a | {i[0], 10'h0});
      land();
      cmp(col, {1'b1, i[1], i[1:0], 11'h15a, i[0]});
      cmp({coln[0].column, coln[1].column}, {11'h35a, 11'h75a});
      u_ctrl.cmd(SDAMD_CMD_PRECHARGE, 1'b0, i[1:0], 13'h1bff);
      land();
      cmp(pre, {2'b10, 4'h1 << i});
    end
    u_ctrl.cmd(SDAMD_CMD_PRECHARGE, 1'b0, 2'h2, 13'h0400);
    land();
    cmp(pre, 6'h3f);
    u_ctrl.cmd(SDAMD_CMD_ACTIVATE, 1'b1, 2'h3, 13'h1fff);
    land();
    cmp(row.valid, 1'b0);
    u_ctrl.cmd(SDAMD_CMD_MODE_SET, 1'b0, 2'h1, 13'h0a33);
    land();
    cmp({ml, mr}, {1'b1, 13'h0a33});
    land();
    cmp({ml, mr}, {1'b0, 13'h0a33});
    $display("command test done");
  endtask
  task automatic t_beats(input logic rd);
    logic [15:0] e;
    for (int i = 0; i < 4; i++) begin
      u_ctrl.beat(rd, i[1], i[1:0], 16'hc3a5);
      land();
      e = {{8{!i[1]}}, {8{!i[0]}}};
      if (rd) cmp({oe, dq & oe}, {e, 16'hc3a5 & e});
      else cmp({wr, en, wd & en}, {|e, e, 16'hc3a5 & e});
      cmp(rd ? oen[0] : enn[0], i[1] ? 16'h0000 : 16'h00ff);
      cmp(rd ? oen[1] : enn[1], i[1] ? 16'h0000 : 16'h000f);
    end
    $display("beat test done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    t_cmds();
    t_beats(1'b0);
    t_beats(1'b1);
    report_and_stop();
  end
  // The tests need well under a thousand cycles.
  initial begin
    #100000;
    fails++;
    report_and_stop();
  end
endmodule
